// ---- verilog/iogcc_defines.vh ----
`ifndef IOGCC_DEFINES_VH
`define IOGCC_DEFINES_VH
// register byte addresses
`define IOGCC_ADDR_SECURE 4'h0
`define IOGCC_ADDR_NONSEC 4'h4
`define IOGCC_ADDR_ALIAS 4'h8
`define IOGCC_ADDR_LSB 2
// field positions
`define IOGCC_SEC_HI 29
`define IOGCC_SEC_LO 28
`define IOGCC_WA_HI 27
`define IOGCC_WA_LO 26
`define IOGCC_RA_HI 25
`define IOGCC_RA_LO 24
`define IOGCC_SH_HI 23
`define IOGCC_SH_LO 22
`define IOGCC_CONF 21
`define IOGCC_MTSEL 20
`define IOGCC_MA_HI 19
`define IOGCC_MA_LO 16
`define IOGCC_BSU_HI 15
`define IOGCC_BSU_LO 14
`define IOGCC_FB 13
`define IOGCC_PTM 12
`define IOGCC_VMNS 11
`define IOGCC_USF 10
`define IOGCC_GSE 9
`define IOGCC_STALL_DISABLE 8
`define IOGCC_TR_HI 7
`define IOGCC_TR_LO 6
`define IOGCC_CFIE 5
`define IOGCC_CFRE 4
`define IOGCC_EXID 3
`define IOGCC_GLOBAL_FAULT_IRQ_ENABLE 2
`define IOGCC_GLOBAL_FAULT_ABORT_ENABLE 1
`define IOGCC_BYP 0
// reset value: only client bypass set, undefined fields cleared
`define IOGCC_RESET 32'h00000001
// writable mask of the secure copy and of the non-secure copy
`define IOGCC_WMASK_S 32'h3fffffff
`define IOGCC_WMASK_NS 32'h0fffffff
`define IOGCC_VMNS_MASK 32'h00000800
`define IOGCC_GSE_MASK 32'h00000200
`define IOGCC_HINT_RSVD 2'h1
// axi responses
`define IOGCC_OKAY 2'h0
`define IOGCC_SLVERR 2'h2
`endif

// ---- verilog/iogcc_global_config.v ----
// Contract
// - secure copy only: bypass security override 00 default, 10 secure, 11 nonsecure
// - write-allocate hint 00 default, 10 allocate, 11 no allocate; resets zero
// - read-allocate hint 00 default, 10 allocate, 11 no allocate; resets zero
// - shareability 00 default, 01 outer, 10 inner, 11 non-shareable
// - match conflict: 0 bypass, 1 conflict fault; may be fixed
// - memory type select 0 default, 1 uses four-bit attribute field
// - barrier upgrade raises barrier domain; reads zero if unsupported
// - force broadcast upgrades client maintenance to inner-shareable broadcast
// - private maintenance 0 joins broadcast TLB maintenance; 1 optional
// - private VMID namespace hint; reserved in secure copy
// - unmatched streams pass when 0, unidentified stream fault when 1
// - global stall enable writable only if global stall implemented
// - stall disable turns off context stall, forces global stall zero
// - optional transient hint 00 default, 10 non-transient, 11 transient
// - config fault interrupt enable raises interrupt on config fault
// - config fault report enable returns abort on config fault
// - extended ID enable selects legacy or extended match format
// - global fault interrupt enable gates the global fault interrupt
// - global fault report enable aborts; else exclusive reported failed
// - client bypass skips translation entirely; resets to one
// - separate secure and nonsecure copies, nonsecure alias for secure
`timescale 1ns/10ps
`include "iogcc_defines.vh"
module iogcc_global_config #(
   parameter HAS_GLOBAL_STALL = 1,
   parameter HAS_STALL_MODEL = 1,
   parameter HAS_BARRIER_UPGRADE = 1,
   parameter HAS_TRANSIENT = 1,
   parameter HAS_CONFIG_FAULT = 1,
   parameter HAS_EXTENDED_ID = 1,
   parameter HAS_STREAM_MATCH = 1,
   parameter CONFLICT_CONFIGURABLE = 1,
   parameter CONFLICT_FIXED = 0
) (
   input wire clk,
   input wire rst,
   input wire [3:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire txnSecure,
   input wire txnBypass,
   input wire txnUnmatched,
   input wire txnConflict,
   input wire globalFault,
   input wire configFault,
   input wire txnExclusive,
   output reg [31:0] secureConfig,
   output reg [31:0] nonsecConfig,
   output reg [1:0] bypassSecurityOverride,
   output reg [1:0] bypassWriteAllocHint,
   output reg [1:0] bypassReadAllocHint,
   output reg [1:0] bypassShareability,
   output reg [3:0] bypassMemoryAttributes,
   output reg bypassUseMemAttr,
   output reg [1:0] barrierUpgrade,
   output reg [1:0] bypassTransientHint,
   output reg forceBroadcast,
   output reg joinBroadcastMaint,
   output reg privateVmNamespace,
   output reg clientBypass,
   output reg unmatchedFault,
   output reg conflictFault,
   output reg contextStallEnable,
   output reg globalStallActive,
   output reg extendedIdEnable,
   output reg faultIrq,
   output reg faultAbort,
   output reg exclusiveFail
);
   reg [31:0] secure_r;
   reg [31:0] nonsec_r;
   reg awHeld_r;
   reg [3:0] awAddr_r;
   reg awSec_r;
   reg wHeld_r;
   reg [31:0] wData_r;
   reg [3:0] wStrb_r;
   reg [31:0] strbMask;
   reg [31:0] wrMaskS;
   reg [31:0] wrMaskNs;
   reg [31:0] secure_nxt;
   reg [31:0] nonsec_nxt;
   reg wrHit;
   reg [31:0] rdVal;
   reg rdHit;
   wire doWrite;
   wire doRead;
   wire [31:0] act;

   assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
   assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
   assign doRead = s_axi_arvalid && !s_axi_rvalid;

   // write channels taken in either order
   always @(posedge clk) begin
      if (rst) begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= 4'h0;
         awSec_r <= 1'b0;
         wData_r <= 32'h00000000;
         wStrb_r <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
            awSec_r <= !s_axi_awprot[1];
         end else if (doWrite) begin
            awHeld_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end else if (doWrite) begin
            wHeld_r <= 1'b0;
         end
      end
   end

   // writable bits per copy; absent fields read zero, a fixed conflict field reads zero from reset and takes CONFLICT_FIXED on the first completed write
   function [31:0] fmask;
      input [31:0] base;
      input [31:0] cur;
      begin
         fmask = base;
         if (!HAS_GLOBAL_STALL || cur[`IOGCC_STALL_DISABLE])
            fmask = fmask & ~`IOGCC_GSE_MASK;
         if (!HAS_STALL_MODEL)
            fmask[`IOGCC_STALL_DISABLE] = 1'b0;
         if (!HAS_BARRIER_UPGRADE) begin
            fmask[`IOGCC_BSU_HI] = 1'b0;
            fmask[`IOGCC_BSU_LO] = 1'b0;
         end
         if (!HAS_TRANSIENT) begin
            fmask[`IOGCC_TR_HI] = 1'b0;
            fmask[`IOGCC_TR_LO] = 1'b0;
         end
         if (!HAS_CONFIG_FAULT) begin
            fmask[`IOGCC_CFIE] = 1'b0;
            fmask[`IOGCC_CFRE] = 1'b0;
         end
         if (!HAS_EXTENDED_ID || !HAS_STREAM_MATCH)
            fmask[`IOGCC_EXID] = 1'b0;
         if (!CONFLICT_CONFIGURABLE)
            fmask[`IOGCC_CONF] = 1'b0;
      end
   endfunction

   // reserved hint encoding 01 is kept as written and decoded as default
   function [1:0] hint;
      input [1:0] f;
      begin
         hint = (f == `IOGCC_HINT_RSVD) ? 2'h0 : f;
      end
   endfunction

   always @* begin
      strbMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}},
         {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
      wrMaskS = fmask(`IOGCC_WMASK_S, secure_r) & ~`IOGCC_VMNS_MASK;
      wrMaskNs = fmask(`IOGCC_WMASK_NS, nonsec_r);
      secure_nxt = secure_r;
      nonsec_nxt = nonsec_r;
      wrHit = 1'b1;
      case (awAddr_r)
         `IOGCC_ADDR_SECURE: begin
            if (awSec_r)
               secure_nxt = (secure_r & ~(wrMaskS & strbMask)) |
                  (wData_r & wrMaskS & strbMask);
            else
               nonsec_nxt = (nonsec_r & ~(wrMaskNs & strbMask)) |
                  (wData_r & wrMaskNs & strbMask);
         end
         `IOGCC_ADDR_ALIAS: begin
            if (awSec_r)
               nonsec_nxt = (nonsec_r & ~(wrMaskNs & strbMask)) |
                  (wData_r & wrMaskNs & strbMask);
            else
               wrHit = 1'b0;
         end
         default: wrHit = 1'b0;
      endcase
      // stall disable forces global stall clear
      if (secure_nxt[`IOGCC_STALL_DISABLE])
         secure_nxt[`IOGCC_GSE] = 1'b0;
      if (nonsec_nxt[`IOGCC_STALL_DISABLE])
         nonsec_nxt[`IOGCC_GSE] = 1'b0;
      if (!CONFLICT_CONFIGURABLE) begin
         secure_nxt[`IOGCC_CONF] = (CONFLICT_FIXED != 0);
         nonsec_nxt[`IOGCC_CONF] = (CONFLICT_FIXED != 0);
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         secure_r <= `IOGCC_RESET;
         nonsec_r <= `IOGCC_RESET;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `IOGCC_OKAY;
      end else begin
         if (doWrite) begin
            secure_r <= secure_nxt;
            nonsec_r <= nonsec_nxt;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrHit ? `IOGCC_OKAY : `IOGCC_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // reads: at the secure address each side sees its own copy; the alias gives secure reads the nonsecure copy
   always @* begin
      rdHit = 1'b1;
      case (s_axi_araddr)
         `IOGCC_ADDR_SECURE:
            rdVal = s_axi_arprot[1] ? nonsec_r : secure_r;
         `IOGCC_ADDR_ALIAS: begin
            rdVal = nonsec_r;
            rdHit = !s_axi_arprot[1];
         end
         default: begin
            rdVal = 32'h00000000;
            rdHit = 1'b0;
         end
      endcase
      if (!rdHit)
         rdVal = 32'h00000000;
   end

   always @(posedge clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `IOGCC_OKAY;
      end else begin
         if (doRead) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdVal;
            s_axi_rresp <= rdHit ? `IOGCC_OKAY : `IOGCC_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // the copy that governs the current client transaction
   assign act = txnSecure ? secure_r : nonsec_r;

   always @(posedge clk) begin
      if (rst) begin
         secureConfig <= `IOGCC_RESET;
         nonsecConfig <= `IOGCC_RESET;
         bypassSecurityOverride <= 2'h0;
         bypassWriteAllocHint <= 2'h0;
         bypassReadAllocHint <= 2'h0;
         bypassShareability <= 2'h0;
         bypassMemoryAttributes <= 4'h0;
         bypassUseMemAttr <= 1'b0;
         barrierUpgrade <= 2'h0;
         bypassTransientHint <= 2'h0;
         forceBroadcast <= 1'b0;
         joinBroadcastMaint <= 1'b0;
         privateVmNamespace <= 1'b0;
         clientBypass <= 1'b1;
         unmatchedFault <= 1'b0;
         conflictFault <= 1'b0;
         contextStallEnable <= 1'b0;
         globalStallActive <= 1'b0;
         extendedIdEnable <= 1'b0;
         faultIrq <= 1'b0;
         faultAbort <= 1'b0;
         exclusiveFail <= 1'b0;
      end else begin
         secureConfig <= secure_r;
         nonsecConfig <= nonsec_r;
         bypassSecurityOverride <= txnSecure ?
            hint(secure_r[`IOGCC_SEC_HI:`IOGCC_SEC_LO]) : 2'h0;
         bypassWriteAllocHint <= hint(act[`IOGCC_WA_HI:`IOGCC_WA_LO]);
         bypassReadAllocHint <= hint(act[`IOGCC_RA_HI:`IOGCC_RA_LO]);
         bypassShareability <= act[`IOGCC_SH_HI:`IOGCC_SH_LO];
         bypassUseMemAttr <= act[`IOGCC_MTSEL];
         bypassMemoryAttributes <= act[`IOGCC_MTSEL] ?
            act[`IOGCC_MA_HI:`IOGCC_MA_LO] : 4'h0;
         barrierUpgrade <= act[`IOGCC_BSU_HI:`IOGCC_BSU_LO];
         bypassTransientHint <= hint(act[`IOGCC_TR_HI:`IOGCC_TR_LO]);
         forceBroadcast <= txnBypass && act[`IOGCC_FB];
         joinBroadcastMaint <= !act[`IOGCC_PTM];
         privateVmNamespace <= !txnSecure && nonsec_r[`IOGCC_VMNS];
         clientBypass <= act[`IOGCC_BYP];
         unmatchedFault <= !act[`IOGCC_BYP] && txnUnmatched &&
            act[`IOGCC_USF];
         conflictFault <= !act[`IOGCC_BYP] && txnConflict &&
            act[`IOGCC_CONF];
         contextStallEnable <= !act[`IOGCC_STALL_DISABLE];
         globalStallActive <= act[`IOGCC_GSE];
         extendedIdEnable <= act[`IOGCC_EXID];
         faultIrq <= (globalFault && act[`IOGCC_GLOBAL_FAULT_IRQ_ENABLE]) ||
            (configFault && act[`IOGCC_CFIE]);
         faultAbort <= (globalFault && act[`IOGCC_GLOBAL_FAULT_ABORT_ENABLE]) ||
            (configFault && act[`IOGCC_CFRE]);
         exclusiveFail <= globalFault && txnExclusive &&
            !act[`IOGCC_GLOBAL_FAULT_ABORT_ENABLE];
      end
   end
endmodule // iogcc_global_config

// ---- tb/iogcc_global_config_asserts.sv ----
`timescale 1ns/10ps
module iogcc_global_config_asserts (
   input logic clk,
   input logic rst,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic [1:0] s_axi_bresp,
   input logic txnSecure,
   input logic txnUnmatched,
   input logic txnConflict,
   input logic globalFault,
   input logic configFault,
   input logic [31:0] secureConfig,
   input logic [31:0] nonsecConfig,
   input logic clientBypass,
   input logic unmatchedFault,
   input logic conflictFault,
   input logic faultIrq,
   input logic faultAbort
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // copy that governed the outputs now shown, one cycle back
   logic txnSec_q;
   always @(posedge clk) txnSec_q <= txnSecure;
   wire [31:0] cfg = txnSec_q ? secureConfig : nonsecConfig;
   reset_value_a: assert property (
      $fell(rst) |-> secureConfig == 32'h1 && nonsecConfig == 32'h1)
      else $error("bad reset value");
   reserved_zero_a: assert property (
      secureConfig[31:30] == 2'h0 && nonsecConfig[31:28] == 4'h0)
      else $error("reserved bits set");
   secure_vmns_a: assert property (
      secureConfig[11] == 1'b0) else $error("secure bit 11 set");
   stall_gse_a: assert property (
      !(secureConfig[8] && secureConfig[9]) &&
      !(nonsecConfig[8] && nonsecConfig[9])) else $error("gse with stall_disable");
   bypass_out_a: assert property (
      !$past(rst) |-> clientBypass == cfg[0])
      else $error("bypass output wrong");
   irq_cause_a: assert property (
      faultIrq |-> $past(globalFault) && cfg[2] ||
      $past(configFault) && cfg[5])
      else $error("irq without cause");
   abort_cause_a: assert property (
      faultAbort |-> $past(globalFault) && cfg[1] ||
      $past(configFault) && cfg[4])
      else $error("abort without cause");
   unmatched_a: assert property (
      unmatchedFault |-> $past(txnUnmatched) && cfg[10] && !cfg[0])
      else $error("unmatched fault without cause");
   conflict_a: assert property (
      conflictFault |-> $past(txnConflict) && cfg[21] && !cfg[0])
      else $error("conflict fault without cause");
   resp_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   cover property (faultIrq);
   cover property (unmatchedFault);
   cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // iogcc_global_config_asserts

bind iogcc_global_config iogcc_global_config_asserts u_chk (.*);

// ---- tb/iommu_global_config_control_tb.sv ----
`timescale 1ns/10ps
`include "iogcc_defines.vh"
module iommu_global_config_control_tb;
   logic clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, txnSecure, txnBypass, txnUnmatched, txnConflict;
   logic globalFault, configFault, txnExclusive;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata;
   logic [31:0] mdl [2];
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, clientBypass, unmatchedFault, conflictFault;
   wire faultIrq, faultAbort;
   wire [1:0] s_axi_bresp, s_axi_rresp, bypassShareability;
   wire [31:0] s_axi_rdata, secureConfig, nonsecConfig;
   int n_mismatch = 0;
   int samples_checked = 0;
   iogcc_global_config dut (.*, .bypassSecurityOverride(),
      .bypassWriteAllocHint(), .bypassReadAllocHint(),
      .bypassMemoryAttributes(), .bypassUseMemAttr(), .barrierUpgrade(),
      .bypassTransientHint(), .forceBroadcast(), .joinBroadcastMaint(),
      .privateVmNamespace(), .contextStallEnable(), .globalStallActive(),
      .extendedIdEnable(), .exclusiveFail());
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic final_report();
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tmo();
      n_mismatch++;
      $display("[FAIL] handshake expected answer seen none");
      final_report();
   endtask
   function automatic logic ok_of(logic [3:0] a, logic sec);
      return a == 4'h0 || (a == 4'h8 && sec);
   endfunction
   // model write: byte lanes, writable bits per copy, stall disable
   function automatic logic [31:0] merge(logic [31:0] c, logic [31:0] d,
         logic [3:0] s, logic sc);
      logic [31:0] m;
      for (int b = 0; b < 4; b++) m[8*b +: 8] = {8{s[b]}};
      m = m & (sc ? 32'h3ffff7ff : 32'h0fffffff);
      c = (c & ~m) | (d & m);
      if (c[8]) c[9] = 1'b0;
      return c;
   endfunction
   task automatic axi_wr(logic [3:0] a, logic sec, logic [31:0] d,
         logic [3:0] s);
      int i;
      int c;
      c = (a == 4'h0 && sec) ? 0 : 1;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_awprot <= {1'b0, !sec, 1'b0};
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 40 && !s_axi_bvalid; i++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      if (s_axi_bvalid !== 1'b1) tmo();
      cmp("bresp", ok_of(a, sec) ? 32'h0 : 32'h2, 32'(s_axi_bresp));
      if (ok_of(a, sec)) mdl[c] = merge(mdl[c], d, s, c == 0);
   endtask
   task automatic axi_rd(logic [3:0] a, logic sec);
      int i;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arprot <= {1'b0, !sec, 1'b0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 40 && !s_axi_rvalid; i++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      if (s_axi_rvalid !== 1'b1) tmo();
      cmp("rresp", ok_of(a, sec) ? 32'h0 : 32'h2, 32'(s_axi_rresp));
      cmp("rdata", !ok_of(a, sec) ? 32'h0 :
         mdl[(a == 4'h0 && sec) ? 0 : 1], s_axi_rdata);
   endtask
   // f: bypass, unmatched, conflict, global fault, config fault
   task automatic chk_txn(logic sec, logic [4:0] f);
      logic [31:0] c;
      c = mdl[sec ? 0 : 1];
      @(posedge clk);
      txnSecure <= sec;
      {txnBypass, txnUnmatched, txnConflict, globalFault, configFault} <= f;
      repeat (2) @(posedge clk);
      #1;
      cmp("bypass", 32'(c[0]), 32'(clientBypass));
      cmp("unmatched", 32'(f[3] & c[10] & !c[0]), 32'(unmatchedFault));
      cmp("conflict", 32'(f[2] & c[21] & !c[0]), 32'(conflictFault));
      cmp("irq", 32'(f[1] & c[2] | f[0] & c[5]), 32'(faultIrq));
      cmp("abort", 32'(f[1] & c[1] | f[0] & c[4]), 32'(faultAbort));
      if (f[4]) cmp("share", 32'(c[23:22]), 32'(bypassShareability));
   endtask
   task automatic do_reset();
      rst <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      mdl[0] = 32'h1;
      mdl[1] = 32'h1;
   endtask
   initial begin
      int k;
      logic [3:0] a;
      logic sec;
      logic [4:0] f;
      logic [31:0] d;
      rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
      {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 13'h0;
      {s_axi_awprot, s_axi_arprot, s_axi_wdata} = 38'h0;
      {txnSecure, txnBypass, txnUnmatched, txnConflict} = 4'h0;
      {globalFault, configFault, txnExclusive} = 3'h0;
      k = $urandom(61272);
      do_reset();
      for (k = 0; k < 3; k++) axi_rd(k == 2 ? 4'h8 : 4'h0, k != 1);
      chk_txn(1'b1, 5'h0);
      axi_wr(4'h0, 1'b1, 32'hffffffff, 4'hf);
      axi_rd(4'h0, 1'b1);
      axi_wr(4'h8, 1'b1, 32'hffffffff, 4'hf);
      axi_rd(4'h0, 1'b0);
      axi_wr(4'h0, 1'b0, 32'h0, 4'hf);
      axi_wr(4'h0, 1'b0, 32'h00000200, 4'hf);
      axi_rd(4'h8, 1'b1);
      for (k = 0; k < 24; k++) begin
         a = 4'(($urandom % 4) * 4);
         sec = 1'($urandom);
         d = $urandom;
         if (mdl[(a == 4'h0 && sec) ? 0 : 1][8]) d[9] = 1'b0;
         axi_wr(a, sec, d, 4'($urandom));
         axi_rd(a, sec);
      end
      axi_wr(4'h0, 1'b1, 32'h00a00436, 4'hf);
      axi_wr(4'h8, 1'b1, 32'h00600424, 4'hf);
      for (k = 0; k < 24; k++) begin
         f = 5'($urandom);
         if (f[3] | f[2]) f[4] = 1'b0;
         chk_txn(1'($urandom), f);
      end
      do_reset();
      axi_rd(4'h8, 1'b1);
      final_report();
   end
endmodule // iommu_global_config_control_tb
